// [include/scfp_regs.vh]
// Register offsets, field positions, command codes and timing figures of the profile block.
`ifndef SCFP_REGS_VH
`define SCFP_REGS_VH
// ==========================================================
// Register byte offsets
`define SCFP_CMD_OFS       8'h00
`define SCFP_PHASE_OFS     8'h04
`define SCFP_EVENT_OFS     8'h08
`define SCFP_IRQMODE_OFS   8'h0c
`define SCFP_LIMMODE_OFS   8'h10
`define SCFP_RANGE_OFS     8'h14
`define SCFP_INITSPD_OFS   8'h18
`define SCFP_DRVSPD_OFS    8'h1c
`define SCFP_ACCEL_OFS     8'h20
`define SCFP_JERK_OFS      8'h24
`define SCFP_PULSES_OFS    8'h28
`define SCFP_SLIMP_OFS     8'h2c
`define SCFP_SLIMM_OFS     8'h30
`define SCFP_LPOS_OFS      8'h34
`define SCFP_CURSPD_OFS    8'h38
// ==========================================================
// Command codes
`define SCFP_CMD_FIX_PLUS  8'h20
`define SCFP_CMD_FIX_MINUS 8'h21
`define SCFP_CMD_DEC_STOP  8'h26
`define SCFP_CMD_SUD_STOP  8'h27
// ==========================================================
// Field positions
`define SCFP_MAIN_DRV      0
`define SCFP_PH_ACC        2
`define SCFP_PH_CONST_PHASE_FLAG       3
`define SCFP_PH_DEC        4
`define SCFP_PH_LIMP       12
`define SCFP_PH_LIMM       13
`define SCFP_EV_CEND       5
`define SCFP_IM_STOP0      1
`define SCFP_IM_STOP1      3
`define SCFP_IM_STOP2      5
`define SCFP_IM_CEND       13
`define SCFP_LM_SLIMP      0
`define SCFP_LM_SLIMM      1
`define SCFP_LM_LIMDEC     2
// ==========================================================
// Reset values
`define SCFP_RANGE_RST     32'h0001_f400
`define SCFP_INITSPD_RST   32'h0000_0064
`define SCFP_DRVSPD_RST    32'h0000_03e8
`define SCFP_ACCEL_RST     32'h0000_0064
`define SCFP_JERK_RST      32'h0000_0064
// ==========================================================
// Rate scaling: speed step modulus (128000 = 125 scaled), jerk divisor 32
`define SCFP_ACC_MOD       32'h0001_f400
`define SCFP_JERK_MUL      5
`endif

// [src/scfp_rate_gen.v]
// Fractional rate generator: emits a tick at inc/mod of the clock rate.
`timescale 1ns/1ps
module scfp_rate_gen #(
  parameter W = 32
) (
  // Clock, reset and freeze.
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // Rate control.
  input wire run,
  input wire [W-1:0] inc,
  input wire [W-1:0] mod,
  // One-cycle tick.
  output reg tick
);
  // ==========================================================
  // Accumulator
  reg [W:0] acc_r;   // Phase accumulator, one bit of headroom.
  wire [W:0] sum = acc_r + {1'b0, inc};  // Next phase before wrap.

  // Accumulate while running; the phase is dropped when idle so every drive starts alike.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= {(W+1){1'b0}};
      tick <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        acc_r <= {(W+1){1'b0}};
        tick <= 1'b0;
      end else if (sum >= {1'b0, mod}) begin
        // Wrap keeps the remainder, so the mean rate is exact.
        acc_r <= sum - {1'b0, mod};
        tick <= 1'b1;
      end else begin
        acc_r <= sum;
        tick <= 1'b0;
      end
    end
  end
endmodule // scfp_rate_gen

// [src/scfp_axis.v]
// One axis of S-curve fixed-pulse profile logic with an AHB-Lite register slave.
`timescale 1ns/1ps
`include "scfp_regs.vh"
// How it works
// - Last pulse leaves speed initial, acceleration zero.
// - Command 26h starts a decelerating stop.
// - Command 27h halts pulses at once.
// - Phase flags: accel D2, const D3, decel D4.
// - Driving flag is 1 while pulses run.
// - Enable D13 raises interrupt on constant end.
// - Constant end sets event bit D5.
// - Brief late constant interval also fires interrupt.
// - Plus limit D12, minus limit D13 shown.
// - Limit mode D2 makes limit decelerate.
// - Software limit, enabled by D0/D1, stops drive.
// - Enabled stop inputs cause decelerating stop.
// - Sudden, emergency, sudden limit, alarm stop instantly.
// - Late zero acceleration shows constant, not decel.
// - Speed rate is setting times fclk over 2R.
// - Acceleration scaled by 125, range, clock squared.
// - Jerk scaled by 62.5M, range, clock cubed.
module scfp_axis (
  // Clock, reset and freeze.
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // AHB-Lite slave.
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output reg [31:0] hrdata,
  output wire hresp,
  // Asynchronous stop pins, active high.
  input wire [1:0] travel_limit_inputs,
  input wire [2:0] axis_stop_inputs,
  input wire emergency_stop_input,
  input wire alarm_input,
  // Drive outputs.
  output reg pulse_plus,
  output reg pulse_minus,
  output wire irq
);
  // ==========================================================
  // State codes
  localparam ST_IDLE = 3'd0;
  localparam ST_ACC_UP = 3'd1;
  localparam ST_ACC_DN = 3'd2;
  localparam ST_CONST = 3'd3;
  localparam ST_DEC_UP = 3'd4;
  localparam ST_DEC_DN = 3'd5;
  localparam ST_TAIL = 3'd6;

  // ==========================================================
  // Registers and state
  reg [15:0] irq_mode_r;      // Input and interrupt mode.
  reg [15:0] lim_mode_r;      // Limit mode.
  reg [31:0] range_r;         // Range setting R.
  reg [31:0] init_spd_r;      // Initial speed setting.
  reg [31:0] drv_spd_r;       // Drive speed setting.
  reg [31:0] accel_r;         // Peak acceleration setting.
  reg [31:0] jerk_r;          // Jerk setting K.
  reg [31:0] pulses_r;        // Programmed pulse count.
  reg [31:0] slim_p_r;        // Plus software limit.
  reg [31:0] slim_m_r;        // Minus software limit.
  reg [31:0] lpos_r;          // Logical position.
  reg [31:0] speed_r;         // Current speed in setting units.
  reg [31:0] acc_now_r;       // Current acceleration magnitude.
  reg [31:0] left_r;          // Pulses still to output.
  reg [31:0] ramp_pulses_r;   // Pulses spent ramping up.
  reg [31:0] mid_r;           // Speed at which a ramp half ends.
  reg [2:0] state_r;          // Profile state.
  reg dir_minus_r;            // Drive direction.
  reg dec_req_r;              // Decelerating stop pending.
  reg cend_r;                 // Sticky constant-end event.
  reg [6:0] sync1_r;          // First sync stage of pins.
  reg [6:0] sync2_r;          // Second sync stage of pins.
  reg [2:0] stop_prev_r;      // Stop inputs one cycle ago.
  reg wr_pend_r;              // Write data phase pending.
  reg [7:0] wr_addr_r;        // Address of pending write.

  // ==========================================================
  // Pin synchronisers
  // Only the second stage is read anywhere below.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_r <= 7'h00;
      sync2_r <= 7'h00;
    end else if (ce) begin
      sync1_r <= {alarm_input, emergency_stop_input, axis_stop_inputs, travel_limit_inputs};
      sync2_r <= sync1_r;
    end
  end

  wire lim_p = sync2_r[0];          // Plus travel limit.
  wire lim_m = sync2_r[1];          // Minus travel limit.
  wire [2:0] stop_in = sync2_r[4:2];  // Stop inputs.
  wire emg = sync2_r[5];            // Emergency.
  wire alarm = sync2_r[6];          // Servo alarm.

  // ==========================================================
  // Bus decode
  wire acc_phase = hsel & hready & htrans[1];
  wire bus_wr = wr_pend_r;
  wire cmd_wr = bus_wr & (wr_addr_r == `SCFP_CMD_OFS);
  wire driving = (state_r != ST_IDLE);

  // Signed compare used by both software limits.
  function lt_s;
    input [31:0] a;
    input [31:0] b;
    begin
      lt_s = $signed(a) < $signed(b);
    end
  endfunction

  // ==========================================================
  // Stop sources
  wire lim_dir = dir_minus_r ? lim_m : lim_p;
  wire [2:0] stop_en = {irq_mode_r[`SCFP_IM_STOP2], irq_mode_r[`SCFP_IM_STOP1],
                        irq_mode_r[`SCFP_IM_STOP0]};
  wire slim_hit = dir_minus_r ? (lim_mode_r[`SCFP_LM_SLIMM] & !lt_s(slim_m_r, lpos_r))
                              : (lim_mode_r[`SCFP_LM_SLIMP] & !lt_s(lpos_r, slim_p_r));
  wire sudden = (cmd_wr & (hwdata[7:0] == `SCFP_CMD_SUD_STOP)) | emg | alarm
              | (lim_dir & !lim_mode_r[`SCFP_LM_LIMDEC]);
  wire stop_rise = |(stop_in & ~stop_prev_r & stop_en);
  wire dec_src = (cmd_wr & (hwdata[7:0] == `SCFP_CMD_DEC_STOP)) | stop_rise | slim_hit
               | (lim_dir & lim_mode_r[`SCFP_LM_LIMDEC]);

  // ==========================================================
  // Rate generators
  wire pulse_tick;  // Output pulse strobe.
  wire spd_tick;    // One speed step.
  wire jerk_tick;   // One acceleration step.
  wire ramping = driving & (state_r != ST_CONST) & (state_r != ST_TAIL);

  scfp_rate_gen #(.W(32)) u_pulse (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .run(driving),
    .inc(speed_r), .mod({range_r[30:0], 1'b0}), .tick(pulse_tick)
  );
  scfp_rate_gen #(.W(32)) u_accel (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .run(ramping),
    .inc(acc_now_r), .mod(`SCFP_ACC_MOD), .tick(spd_tick)
  );
  scfp_rate_gen #(.W(32)) u_jerk (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .run(ramping),
    .inc(32'h0000_0001), .mod(jerk_r << `SCFP_JERK_MUL), .tick(jerk_tick)
  );

  wire last_pulse = pulse_tick & (left_r == 32'h0000_0001);
  wire [31:0] spd_up = (speed_r < drv_spd_r) ? speed_r + 32'h0000_0001 : drv_spd_r;
  wire [31:0] spd_dn = (speed_r > init_spd_r) ? speed_r - 32'h0000_0001 : init_spd_r;
  wire [31:0] acc_inc = (acc_now_r < accel_r) ? acc_now_r + 32'h0000_0001 : accel_r;
  wire [31:0] acc_dec = (acc_now_r != 32'h0) ? acc_now_r - 32'h0000_0001 : 32'h0;
  // Deceleration must begin once the pulses left match the ramp-up cost.
  wire need_dec = dec_req_r | dec_src | (left_r <= ramp_pulses_r);

  // ==========================================================
  // Profile state machine
  // Sudden stops and the last pulse take priority over the phase moves.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
      speed_r <= 32'h0;
      acc_now_r <= 32'h0;
      left_r <= 32'h0;
      ramp_pulses_r <= 32'h0;
      mid_r <= 32'h0;
      dir_minus_r <= 1'b0;
      dec_req_r <= 1'b0;
      lpos_r <= 32'h0;
      pulse_plus <= 1'b0;
      pulse_minus <= 1'b0;
      stop_prev_r <= 3'h0;
    end else if (ce) begin
      stop_prev_r <= stop_in;
      pulse_plus <= pulse_tick & !dir_minus_r;
      pulse_minus <= pulse_tick & dir_minus_r;
      if (bus_wr & (wr_addr_r == `SCFP_LPOS_OFS)) begin
        lpos_r <= hwdata;
      end else if (pulse_tick) begin
        lpos_r <= dir_minus_r ? lpos_r - 32'h0000_0001 : lpos_r + 32'h0000_0001;
      end
      if (pulse_tick) begin
        left_r <= left_r - 32'h0000_0001;
        if (state_r == ST_ACC_UP || state_r == ST_ACC_DN) begin
          ramp_pulses_r <= ramp_pulses_r + 32'h0000_0001;
        end
      end
      if (dec_src & driving) begin
        dec_req_r <= 1'b1;
      end
      case (state_r)
        ST_IDLE: begin
          // Start commands load the count and begin at the initial speed.
          if (cmd_wr & ((hwdata[7:0] == `SCFP_CMD_FIX_PLUS) |
                        (hwdata[7:0] == `SCFP_CMD_FIX_MINUS)) & (pulses_r != 32'h0)) begin
            state_r <= ST_ACC_UP;
            dir_minus_r <= hwdata[0];
            left_r <= pulses_r;
            speed_r <= init_spd_r;
            acc_now_r <= 32'h0;
            ramp_pulses_r <= 32'h0;
            dec_req_r <= 1'b0;
            mid_r <= init_spd_r + ((drv_spd_r - init_spd_r) >> 1);
          end
        end
        default: begin
          if (sudden) begin
            state_r <= ST_IDLE;
            acc_now_r <= 32'h0;
            speed_r <= 32'h0;
          end else if (last_pulse) begin
            state_r <= ST_IDLE;
            speed_r <= init_spd_r;
            acc_now_r <= 32'h0;
          end else begin
            case (state_r)
              ST_ACC_UP: begin
                if (need_dec) begin
                  state_r <= ST_DEC_UP;
                  acc_now_r <= 32'h0;
                  mid_r <= init_spd_r + ((speed_r - init_spd_r) >> 1);
                end else if (speed_r >= mid_r) begin
                  state_r <= ST_ACC_DN;
                end else begin
                  if (jerk_tick) acc_now_r <= acc_inc;
                  if (spd_tick) speed_r <= spd_up;
                end
              end
              ST_ACC_DN: begin
                if (need_dec) begin
                  state_r <= ST_DEC_UP;
                  acc_now_r <= 32'h0;
                  mid_r <= init_spd_r + ((speed_r - init_spd_r) >> 1);
                end else if (acc_now_r == 32'h0 || speed_r >= drv_spd_r) begin
                  state_r <= ST_CONST;
                  acc_now_r <= 32'h0;
                end else begin
                  if (jerk_tick) acc_now_r <= acc_dec;
                  if (spd_tick) speed_r <= spd_up;
                end
              end
              ST_CONST: begin
                if (need_dec) begin
                  state_r <= ST_DEC_UP;
                  mid_r <= init_spd_r + ((speed_r - init_spd_r) >> 1);
                end
              end
              ST_DEC_UP: begin
                if (speed_r <= mid_r) begin
                  state_r <= ST_DEC_DN;
                end else begin
                  if (jerk_tick) acc_now_r <= acc_inc;
                  if (spd_tick) speed_r <= spd_dn;
                end
              end
              ST_DEC_DN: begin
                if (speed_r <= init_spd_r) begin
                  // decelerating stop ends at the initial speed
                  acc_now_r <= 32'h0;
                  if (dec_req_r) state_r <= ST_IDLE;
                end else if (acc_now_r == 32'h0) begin
                  state_r <= ST_TAIL;
                end else begin
                  if (jerk_tick) acc_now_r <= acc_dec;
                  if (spd_tick) speed_r <= spd_dn;
                end
              end
              ST_TAIL: begin
                // Held at speed; only the count or a sudden stop ends it.
                state_r <= ST_TAIL;
              end
              default: state_r <= ST_IDLE;
            endcase
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Constant-end event
  // leaving any constant region sets the event.
  wire cend_set = ((state_r == ST_CONST) & (need_dec | sudden | last_pulse))
                | ((state_r == ST_TAIL) & (sudden | last_pulse));
  wire cend_clr = bus_wr & (wr_addr_r == `SCFP_EVENT_OFS) & hwdata[`SCFP_EV_CEND];

  // Set wins over a simultaneous write-one clear.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cend_r <= 1'b0;
    end else if (ce) begin
      cend_r <= cend_set | (cend_r & !cend_clr);
    end
  end

  assign irq = irq_mode_r[`SCFP_IM_CEND] & cend_r;

  // ==========================================================
  // Status words
  wire [31:0] main_status_reg = {31'h0, driving};
  wire [31:0] phase_status_reg = {18'h0, lim_m, lim_p, 7'h0,
    (state_r == ST_DEC_UP) | (state_r == ST_DEC_DN),
    (state_r == ST_CONST) | (state_r == ST_TAIL),
    (state_r == ST_ACC_UP) | (state_r == ST_ACC_DN), 2'h0};
  wire [31:0] event_status_reg = {26'h0, cend_r, 5'h0};

  // ==========================================================
  // Register writes
  // Writes take effect in the data phase, when hwdata is valid.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      irq_mode_r <= 16'h0000;
      lim_mode_r <= 16'h0000;
      range_r <= `SCFP_RANGE_RST;
      init_spd_r <= `SCFP_INITSPD_RST;
      drv_spd_r <= `SCFP_DRVSPD_RST;
      accel_r <= `SCFP_ACCEL_RST;
      jerk_r <= `SCFP_JERK_RST;
      pulses_r <= 32'h0;
      slim_p_r <= 32'h7fff_ffff;
      slim_m_r <= 32'h8000_0000;
    end else if (ce) begin
      wr_pend_r <= acc_phase & hwrite;
      wr_addr_r <= {haddr[7:2], 2'b00};
      if (bus_wr) begin
        case (wr_addr_r)
          `SCFP_IRQMODE_OFS: irq_mode_r <= hwdata[15:0];
          `SCFP_LIMMODE_OFS: lim_mode_r <= hwdata[15:0];
          `SCFP_RANGE_OFS: range_r <= hwdata;
          `SCFP_INITSPD_OFS: init_spd_r <= hwdata;
          `SCFP_DRVSPD_OFS: drv_spd_r <= hwdata;
          `SCFP_ACCEL_OFS: accel_r <= hwdata;
          `SCFP_JERK_OFS: jerk_r <= hwdata;
          `SCFP_PULSES_OFS: pulses_r <= hwdata;
          `SCFP_SLIMP_OFS: slim_p_r <= hwdata;
          `SCFP_SLIMM_OFS: slim_m_r <= hwdata;
          default: wr_pend_r <= acc_phase & hwrite;
        endcase
      end
    end
  end

  // ==========================================================
  // Register reads
  // Read data is captured at the address phase so it stands through the data phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (ce & acc_phase & !hwrite) begin
      case ({haddr[7:2], 2'b00})
        `SCFP_CMD_OFS: hrdata <= main_status_reg;
        `SCFP_PHASE_OFS: hrdata <= phase_status_reg;
        `SCFP_EVENT_OFS: hrdata <= event_status_reg;
        `SCFP_IRQMODE_OFS: hrdata <= {16'h0, irq_mode_r};
        `SCFP_LIMMODE_OFS: hrdata <= {16'h0, lim_mode_r};
        `SCFP_RANGE_OFS: hrdata <= range_r;
        `SCFP_INITSPD_OFS: hrdata <= init_spd_r;
        `SCFP_DRVSPD_OFS: hrdata <= drv_spd_r;
        `SCFP_ACCEL_OFS: hrdata <= accel_r;
        `SCFP_JERK_OFS: hrdata <= jerk_r;
        `SCFP_PULSES_OFS: hrdata <= pulses_r;
        `SCFP_SLIMP_OFS: hrdata <= slim_p_r;
        `SCFP_SLIMM_OFS: hrdata <= slim_m_r;
        `SCFP_LPOS_OFS: hrdata <= lpos_r;
        `SCFP_CURSPD_OFS: hrdata <= speed_r;
        default: hrdata <= 32'h0;
      endcase
    end
  end

  // Zero-wait slave; it stalls the bus only while frozen.
  assign hreadyout = ce;
  assign hresp = 1'b0;
endmodule // scfp_axis

// [tb/scfp_axis_checker.sv]
// Port-level assertions for the S-curve fixed-pulse axis.
`timescale 1ns/1ps
`include "scfp_regs.vh"
module scfp_axis_checker (
  // Clock, reset and freeze.
  input wire hclk,
  input wire hresetn,
  input wire ce,
  // Bus side.
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire hreadyout,
  input wire [31:0] hrdata,
  input wire hresp,
  // Stop pins and drive outputs.
  input wire emergency_stop_input,
  input wire alarm_input,
  input wire pulse_plus,
  input wire pulse_minus,
  input wire irq
);
  // ==========================================================
  // Common clocking.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // An address phase that the slave accepts.
  wire taken = hsel & hready & htrans[1] & ce;
  // ==========================================================
  // Assertions.
  hresp_okay_a: assert property (hresp == 1'b0)
    else $error("slave answered with an error response");
  ready_follow_a: assert property (hreadyout == ce)
    else $error("ready does not follow the clock enable");
  dir_exclusive_a: assert property (!(pulse_plus && pulse_minus))
    else $error("both direction pulses high together");
  pulse_single_a: assert property (pulse_plus && ce |=> !pulse_plus)
    else $error("plus pulse wider than one cycle");
  emerg_halt_a: assert property (emergency_stop_input[*6] |-> !pulse_plus && !pulse_minus)
    else $error("pulses continue under emergency");
  alarm_halt_a: assert property (alarm_input[*6] |-> !(pulse_plus || pulse_minus))
    else $error("pulses continue under alarm");
  sudden_cmd_a: assert property ((taken && hwrite && haddr == `SCFP_CMD_OFS) ##1
    (hwdata[7:0] == `SCFP_CMD_SUD_STOP) |-> ##3 (!pulse_plus && !pulse_minus)[*6])
    else $error("pulses after sudden stop command");
  irq_disable_a: assert property ((taken && hwrite && haddr == `SCFP_IRQMODE_OFS) ##1
    !hwdata[13] |=> !irq)
    else $error("interrupt stays up after enable cleared");
  unmapped_zero_a: assert property (taken && !hwrite && haddr == 8'h3c |=> hrdata == 32'h0)
    else $error("unmapped read returned nonzero data");
  freeze_hold_a: assert property (!ce |=> $stable(pulse_plus) && $stable(pulse_minus))
    else $error("pulse outputs moved while frozen");
endmodule // scfp_axis_checker

// [tb/scfp_motor_model.sv]
// Motor driver stand-in that counts step pulses in each direction.
`timescale 1ns/1ps
module scfp_motor_model (
  // Clock and reset.
  input wire hclk,
  input wire hresetn,
  // Step pulses from the axis.
  input wire pulse_plus,
  input wire pulse_minus,
  // Running step totals for the bench.
  output int n_plus,
  output int n_minus
);
  // ==========================================================
  // Step counting: one step per rising edge, so a pulse held high through a freeze counts once.
  logic pp_q;  // Plus pulse one cycle ago.
  logic pm_q;  // Minus pulse one cycle ago.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      n_plus <= 0;
      n_minus <= 0;
      pp_q <= 1'b0;
      pm_q <= 1'b0;
    end else begin
      n_plus <= n_plus + (pulse_plus & !pp_q);
      n_minus <= n_minus + (pulse_minus & !pm_q);
      pp_q <= pulse_plus;
      pm_q <= pulse_minus;
    end
  end
endmodule // scfp_motor_model

// [tb/testbench.sv]
// Self-checking bench for the S-curve fixed-pulse axis.
`timescale 1ns/1ps
`include "scfp_regs.vh"
module testbench;
  // ==========================================================
  // Bench signals.
  logic hclk = 0, hresetn = 0, ce = 1, hsel = 0, hwrite = 0, emg = 0, alm = 0, hit = 0;
  logic [7:0] haddr = 0;
  logic [1:0] htrans = 0, lim = 0;
  logic [2:0] stp = 0;
  logic [31:0] hwdata = 0, d;
  logic [4:0] seen;
  logic [7:0] ofs [5] = '{`SCFP_RANGE_OFS, `SCFP_INITSPD_OFS, `SCFP_DRVSPD_OFS,
    `SCFP_ACCEL_OFS, `SCFP_JERK_OFS};
  logic [31:0] rst [5] = '{`SCFP_RANGE_RST, `SCFP_INITSPD_RST, `SCFP_DRVSPD_RST,
    `SCFP_ACCEL_RST, `SCFP_JERK_RST};
  wire hreadyout, hresp, pp, pm, irq;
  wire [31:0] hrdata;
  int n_mismatch = 0, num_checks = 0, np, nm;
  always #25 hclk = ~hclk;
  // Device and motor driver; the one slave's ready is the bus ready.
  scfp_axis scfp_axis_inst (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .travel_limit_inputs(lim), .axis_stop_inputs(stp), .emergency_stop_input(emg),
    .alarm_input(alm), .pulse_plus(pp), .pulse_minus(pm), .irq(irq));
  scfp_motor_model scfp_motor_model_inst (.hclk(hclk), .hresetn(hresetn),
    .pulse_plus(pp), .pulse_minus(pm), .n_plus(np), .n_minus(nm));
  // ==========================================================
  // Bus and check tasks; values read just after an edge are the sampled ones.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge hclk);
    {hsel, hwrite, haddr, htrans} <= {1'b1, w, a, 2'h2};
    do @(posedge hclk); while (!hreadyout);
    {hsel, htrans, hwdata} <= {1'b0, 2'h0, v};
    do @(posedge hclk); while (!hreadyout);
    d = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    xfer(1'b1, a, v);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  // Poll until the drive ends; a stuck drive runs out the bound.
  task automatic idle(input int n);
    int k;
    k = 0;
    do begin
      rd(`SCFP_CMD_OFS);
      k++;
    end while (d[0] && k < n);
  endtask
  // Start a fixed-pulse drive and let it get going.
  task automatic go(input logic [7:0] c, input int n);
    wr(`SCFP_PULSES_OFS, n);
    wr(`SCFP_CMD_OFS, {24'h0, c});
    repeat (300) @(posedge hclk);
  endtask
  // A sudden halt: no step may follow and the driving flag is down.
  // Steps already launched through the pin synchronisers get time to land first.
  task automatic halted;
    int s;
    repeat (8) @(posedge hclk);
    s = np + nm;
    repeat (100) @(posedge hclk);
    chk(np + nm, s);
    rd(`SCFP_CMD_OFS);
    chk(d[0], 1'b0);
  endtask
  // Watch phases to the end; handle the constant-end interrupt once.
  task automatic watch(input int n);
    int k;
    k = 0;
    seen = 0;
    do begin
      rd(`SCFP_PHASE_OFS);
      seen = seen | d[4:0];
      if (irq && !hit) begin
        hit = 1;
        rd(`SCFP_EVENT_OFS);
        chk(d[5], 1'b1);
        wr(`SCFP_IRQMODE_OFS, 32'h0);
        wr(`SCFP_EVENT_OFS, 32'h20);
      end
      // Freeze briefly once, so a stall mid-drive is exercised.
      if (k == 50) begin
        ce <= 0;
        repeat (6) @(posedge hclk);
        ce <= 1;
      end
      rd(`SCFP_CMD_OFS);
      k++;
    end while (d[0] && k < n);
  endtask
  task wrap_up;
    $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Watchdog sized well beyond the expected run of about 58000 cycles.
  initial begin
    repeat (95000) @(posedge hclk);
    n_mismatch++;
    wrap_up;
  end
  // ==========================================================
  // Test sequence.
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1;
    foreach (ofs[k]) begin
      rd(ofs[k]);
      chk(d, rst[k]);
    end
    rd(8'h3c);
    chk(d, 32'h0);
    $display("test defaults done");
    // Small range keeps the profile short.
    wr(`SCFP_RANGE_OFS, 64);
    wr(`SCFP_INITSPD_OFS, 8);
    wr(`SCFP_DRVSPD_OFS, 16);
    wr(`SCFP_ACCEL_OFS, 200);
    wr(`SCFP_JERK_OFS, 1);
    wr(`SCFP_IRQMODE_OFS, 32'h2000);
    go(`SCFP_CMD_FIX_PLUS, 3000);
    watch(9000);
    chk(d[0], 1'b0);
    chk(np, 3000);
    chk(seen[4:2], 3'b111);
    chk(hit, 1'b1);
    rd(`SCFP_CURSPD_OFS);
    chk(d, 32'h0000_0008);
    // The target stays well inside both software limits.
    go(`SCFP_CMD_FIX_MINUS, 20);
    idle(300);
    chk(nm, 20);
    $display("test profile done");
    go(`SCFP_CMD_FIX_PLUS, 100000);
    // Stop only once at constant speed, at or above the midway speed.
    do rd(`SCFP_PHASE_OFS); while (!d[3]);
    rd(`SCFP_CURSPD_OFS);
    chk(d >= 32'h0000_000c, 1'b1);
    wr(`SCFP_CMD_OFS, `SCFP_CMD_DEC_STOP);
    watch(3000);
    chk(seen[4], 1'b1);
    chk(d[0], 1'b0);
    go(`SCFP_CMD_FIX_PLUS, 100000);
    wr(`SCFP_CMD_OFS, `SCFP_CMD_SUD_STOP);
    halted;
    for (int k = 0; k < 2; k++) begin
      go(`SCFP_CMD_FIX_PLUS, 100000);
      {emg, alm} <= 2'b10 >> k;
      halted;
      {emg, alm} <= 2'b00;
    end
    $display("test stops done");
    wr(`SCFP_LIMMODE_OFS, 32'h0);
    go(`SCFP_CMD_FIX_PLUS, 100000);
    lim <= 2'b01;
    halted;
    rd(`SCFP_PHASE_OFS);
    chk(d[13:12], 2'b01);
    lim <= 2'b10;
    repeat (4) @(posedge hclk);
    rd(`SCFP_PHASE_OFS);
    chk(d[13:12], 2'b10);
    lim <= 2'b00;
    wr(`SCFP_LIMMODE_OFS, 32'h4);
    go(`SCFP_CMD_FIX_PLUS, 100000);
    lim <= 2'b01;
    idle(3000);
    chk(d[0], 1'b0);
    lim <= 2'b00;
    for (int k = 0; k < 3; k++) begin
      wr(`SCFP_IRQMODE_OFS, 32'h2 << (2 * k));
      go(`SCFP_CMD_FIX_PLUS, 100000);
      stp <= 3'h1 << k;
      idle(3000);
      chk(d[0], 1'b0);
      stp <= 3'h0;
    end
    wr(`SCFP_IRQMODE_OFS, 32'h0);
    go(`SCFP_CMD_FIX_PLUS, 100000);
    stp <= 3'h7;
    repeat (10) @(posedge hclk);
    rd(`SCFP_CMD_OFS);
    chk(d[0], 1'b1);
    stp <= 3'h0;
    wr(`SCFP_CMD_OFS, `SCFP_CMD_SUD_STOP);
    $display("test limits done");
    rd(`SCFP_LPOS_OFS);
    wr(`SCFP_SLIMP_OFS, d + 40);
    wr(`SCFP_LIMMODE_OFS, 32'h1);
    go(`SCFP_CMD_FIX_PLUS, 100000);
    idle(3000);
    chk(d[0], 1'b0);
    $display("test soft limit done");
    wrap_up;
  end
endmodule // testbench
bind scfp_axis scfp_axis_checker scfp_axis_checker_inst (.hclk(hclk), .hresetn(hresetn),
  .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .emergency_stop_input(emergency_stop_input), .alarm_input(alarm_input),
  .pulse_plus(pulse_plus), .pulse_minus(pulse_minus), .irq(irq));
